// ===== lcob_defines.svh
`ifndef LCOB_DEFINES_SVH
`define LCOB_DEFINES_SVH

// ==========================================================
// Register offsets
`define LCOB_OFS_CH4CTRL 4'h0
`define LCOB_OFS_OBSER 4'h1
`define LCOB_OFS_ISTAT 4'h2
`define LCOB_OFS_IMASK 4'h3
`define LCOB_OFS_C1ADRH 4'h4
`define LCOB_OFS_C1ADRL 4'h5
`define LCOB_OFS_C1CTRL 4'h6

// ==========================================================
// Field positions
`define LCOB_BIT_CH4_EN 6
`define LCOB_BIT_CH4_RXIE 5
`define LCOB_BIT_OUTBUF_EMPTY_IRQ_ENABLE 7
`define LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG 6
`define LCOB_BIT_SERE 1
`define LCOB_BIT_C1EN 0
`define LCOB_BIT_HOST_SEL 2
`define LCOB_IRQ_RX4 0
`define LCOB_IRQ_OBE 1
`define LCOB_IRQ_SERREF 2

// ==========================================================
// Write masks and reset values
`define LCOB_CH4CTRL_WMASK 8'h60
`define LCOB_OBSER_WMASK 8'h82
`define LCOB_C1CTRL_WMASK 8'h01
`define LCOB_C1ADRL_WMASK 8'hFB
`define LCOB_ISTAT_WMASK 8'h07
`define LCOB_REG_RST 8'h00
`define LCOB_C1ADRH_RST 8'h00
`define LCOB_C1ADRL_RST 8'h60

`endif

// ===== lcob_fall_det.sv
module lcob_fall_det #(
    parameter int N = 5
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [N-1:0] i_level,
    output logic [N-1:0] o_fall
);

    logic [N-1:0] prev_q;
    logic [N-1:0] prev_d;

    if (N < 1) begin : g_chk
        $error("lcob_fall_det: N must be at least 1");
    end

    // ==========================================================
    // One previous-value flop and edge term per flag
    for (genvar g = 0; g < N; g++) begin : g_bit
        always_comb begin
            prev_d[g] = i_level[g];
            o_fall[g] = prev_q[g] & ~i_level[g];
        end
        always_ff @(posedge i_clk_sys or negedge i_rstn) begin
            if (!i_rstn) begin
                prev_q[g] <= 1'b0;
            end else begin
                prev_q[g] <= prev_d[g];
            end
        end
    end

endmodule

// ===== lcob_host_model.sv
module lcob_host_model (
    input wire logic i_clk_sys,
    output logic o_io_valid,
    output logic o_io_write,
    output logic [15:0] o_io_addr,
    output logic o_serial_hit
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_io_valid = 1'b0;
        o_io_write = 1'b0;
        o_io_addr = 16'hFFFF;
        o_serial_hit = 1'b0;
    end

    // ==========================================================
    // One I/O cycle; qualifiers scrambled once released
    task automatic io(input logic wr, input logic [15:0] a, input logic hit);
        @(posedge i_clk_sys);
        o_io_valid <= 1'b1;
        o_io_write <= wr;
        o_io_addr <= a;
        o_serial_hit <= hit;
        @(posedge i_clk_sys);
        o_io_valid <= 1'b0;
        o_io_write <= ~wr;
        o_io_addr <= ~a;
        o_serial_hit <= ~hit;
    endtask
endmodule

// ===== lcob_pkg.sv
package lcob_pkg;

    // Channel 1 host register selected by a matching I/O cycle
    typedef enum logic [2:0] {
        LCOB_SEL_NONE = 3'b000,
        LCOB_SEL_DATA_WR = 3'b001,
        LCOB_SEL_CMD_WR = 3'b010,
        LCOB_SEL_ODR_RD = 3'b011,
        LCOB_SEL_STR_RD = 3'b100
    } lcob_sel_t;

endpackage

// ===== lcob_top.sv
`include "lcob_defines.svh"

// Summary of operation
// - Channel 4 decodes addresses only when enabled
// - Channel 4 receive request gated by enable
// - Output-empty request gated by its enable
// - Any output-full falling edge sets empty flag
// - Empty flag clears on zero after reading one
// - LPC hardware or software reset clears flag
// - Host serial access only when enabled
// - Address bit 2 picks data or command/status
module lcob_top #(
    parameter int AW = 4,
    parameter int NOBF = 5
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_io_valid,
    input wire logic i_io_write,
    input wire logic [15:0] i_io_addr,
    input wire logic [15:0] i_chan4_host_address,
    input wire logic i_serial_hit,
    input wire logic [NOBF-1:0] i_outbuf_full,
    input wire logic i_chan4_rx_full_irq,
    input wire logic i_lpc_hw_reset,
    input wire logic i_lpc_sw_reset,
    output logic o_chan4_match,
    output lcob_pkg::lcob_sel_t o_chan1_sel,
    output logic o_serial_grant,
    output logic o_serial_refused,
    output logic o_chan4_rx_irq,
    output logic o_outbuf_empty_irq,
    output logic o_chan1_enable,
    output logic o_irq
);

    if (AW < 3) begin : g_chk_aw
        $error("lcob_top: AW must be at least 3");
    end
    if (NOBF != 5) begin : g_chk_obf
        $error("lcob_top: NOBF must be 5");
    end

    // ==========================================================
    // Register state
    logic [7:0] ch4ctrl_q, ch4ctrl_d;
    logic [7:0] obser_q, obser_d;
    logic [7:0] istat_q, istat_d;
    logic [7:0] imask_q, imask_d;
    logic [7:0] c1adrh_q, c1adrh_d;
    logic [7:0] c1adrl_q, c1adrl_d;
    logic [7:0] c1ctrl_q, c1ctrl_d;
    logic armed_q, armed_d;
    logic [7:0] rdata_q, rdata_d;
    logic [NOBF-1:0] obf_fall;
    logic obf_any_fall;
    logic lpc_rst;
    logic wr_obser;
    logic [7:0] rd_mux;

    lcob_fall_det #(
        .N(NOBF)
    ) u_fall (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_level(i_outbuf_full),
        .o_fall(obf_fall)
    );

    // ==========================================================
    // Register file next state
    always_comb begin
        obf_any_fall = |obf_fall;
        lpc_rst = i_lpc_hw_reset | i_lpc_sw_reset;
        wr_obser = i_wr && (i_addr == AW'(`LCOB_OFS_OBSER));
        ch4ctrl_d = ch4ctrl_q;
        obser_d = obser_q;
        imask_d = imask_q;
        c1adrh_d = c1adrh_q;
        c1adrl_d = c1adrl_q;
        c1ctrl_d = c1ctrl_q;
        armed_d = armed_q;
        istat_d = istat_q;
        if (i_wr) begin
            case (i_addr)
                AW'(`LCOB_OFS_CH4CTRL): begin
                    ch4ctrl_d = i_wdata & `LCOB_CH4CTRL_WMASK;
                end
                AW'(`LCOB_OFS_OBSER): begin
                    obser_d = (i_wdata & `LCOB_OBSER_WMASK)
                        | (obser_q & ~`LCOB_OBSER_WMASK);
                end
                AW'(`LCOB_OFS_ISTAT): begin
                    istat_d = istat_q & ~(i_wdata & `LCOB_ISTAT_WMASK);
                end
                AW'(`LCOB_OFS_IMASK): begin
                    imask_d = i_wdata & `LCOB_ISTAT_WMASK;
                end
                AW'(`LCOB_OFS_C1ADRH): begin
                    c1adrh_d = i_wdata;
                end
                AW'(`LCOB_OFS_C1ADRL): begin
                    c1adrl_d = i_wdata & `LCOB_C1ADRL_WMASK;
                end
                AW'(`LCOB_OFS_C1CTRL): begin
                    c1ctrl_d = i_wdata & `LCOB_C1CTRL_WMASK;
                end
                default: begin
                end
            endcase
        end
        // Zero write clears only after a read of one; a one is ignored
        if (wr_obser) begin
            armed_d = 1'b0;
            if (armed_q && !i_wdata[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG]) begin
                obser_d[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG] = 1'b0;
            end
        end
        if (i_rd && (i_addr == AW'(`LCOB_OFS_OBSER))
                && obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG]) begin
            armed_d = 1'b1;
        end
        if (obf_any_fall) begin
            obser_d[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG] = 1'b1;
        end
        if (lpc_rst) begin
            obser_d[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG] = 1'b0;
            armed_d = 1'b0;
        end
        // Sticky events, set wins over the clear
        if (i_chan4_rx_full_irq && ch4ctrl_q[`LCOB_BIT_CH4_RXIE]) begin
            istat_d[`LCOB_IRQ_RX4] = 1'b1;
        end
        if (obf_any_fall) begin
            istat_d[`LCOB_IRQ_OBE] = 1'b1;
        end
        if (i_io_valid && i_serial_hit && !obser_q[`LCOB_BIT_SERE]) begin
            istat_d[`LCOB_IRQ_SERREF] = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ch4ctrl_q <= `LCOB_REG_RST;
            obser_q <= `LCOB_REG_RST;
            istat_q <= `LCOB_REG_RST;
            imask_q <= `LCOB_REG_RST;
            c1adrh_q <= `LCOB_C1ADRH_RST;
            c1adrl_q <= `LCOB_C1ADRL_RST;
            c1ctrl_q <= `LCOB_REG_RST;
            armed_q <= 1'b0;
        end else begin
            ch4ctrl_q <= ch4ctrl_d;
            obser_q <= obser_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
            c1adrh_q <= c1adrh_d;
            c1adrl_q <= c1adrl_d;
            c1ctrl_q <= c1ctrl_d;
            armed_q <= armed_d;
        end
    end

    // ==========================================================
    // Read port, data valid the cycle after the strobe
    always_comb begin
        case (i_addr)
            AW'(`LCOB_OFS_CH4CTRL): rd_mux = ch4ctrl_q;
            AW'(`LCOB_OFS_OBSER): rd_mux = obser_q;
            AW'(`LCOB_OFS_ISTAT): rd_mux = istat_q;
            AW'(`LCOB_OFS_IMASK): rd_mux = imask_q;
            AW'(`LCOB_OFS_C1ADRH): rd_mux = c1adrh_q;
            AW'(`LCOB_OFS_C1ADRL): rd_mux = c1adrl_q;
            AW'(`LCOB_OFS_C1CTRL): rd_mux = c1ctrl_q;
            default: rd_mux = `LCOB_REG_RST;
        endcase
        rdata_d = i_rd ? rd_mux : `LCOB_REG_RST;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= `LCOB_REG_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Host cycle decode and request outputs
    logic ch4_hit, c1_hit;
    logic ch4_match_d, ser_grant_d, ser_ref_d, rx_irq_d, obe_irq_d;
    logic irq_d;
    lcob_pkg::lcob_sel_t c1_sel_d;
    logic ch4_match_q, ser_grant_q, ser_ref_q, rx_irq_q, obe_irq_q;
    logic irq_q;
    lcob_pkg::lcob_sel_t c1_sel_q;

    always_comb begin
        ch4_hit = (i_io_addr[15:3] == i_chan4_host_address[15:3])
            && (i_io_addr[1:0] == i_chan4_host_address[1:0]);
        c1_hit = (i_io_addr[15:3] == {c1adrh_q, c1adrl_q[7:3]})
            && (i_io_addr[1:0] == c1adrl_q[1:0]);
        ch4_match_d = i_io_valid && ch4_hit
            && ch4ctrl_q[`LCOB_BIT_CH4_EN];
        c1_sel_d = lcob_pkg::LCOB_SEL_NONE;
        if (i_io_valid && c1_hit && c1ctrl_q[`LCOB_BIT_C1EN]) begin
            case ({i_io_write, i_io_addr[`LCOB_BIT_HOST_SEL]})
                2'b10: c1_sel_d = lcob_pkg::LCOB_SEL_DATA_WR;
                2'b11: c1_sel_d = lcob_pkg::LCOB_SEL_CMD_WR;
                2'b00: c1_sel_d = lcob_pkg::LCOB_SEL_ODR_RD;
                2'b01: c1_sel_d = lcob_pkg::LCOB_SEL_STR_RD;
                default: c1_sel_d = lcob_pkg::LCOB_SEL_NONE;
            endcase
        end
        ser_grant_d = i_io_valid && i_serial_hit
            && obser_q[`LCOB_BIT_SERE];
        ser_ref_d = i_io_valid && i_serial_hit
            && !obser_q[`LCOB_BIT_SERE];
        rx_irq_d = i_chan4_rx_full_irq
            && ch4ctrl_q[`LCOB_BIT_CH4_RXIE];
        obe_irq_d = obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG]
            && obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_ENABLE];
        irq_d = |(istat_q & imask_q);
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ch4_match_q <= 1'b0;
            c1_sel_q <= lcob_pkg::LCOB_SEL_NONE;
            ser_grant_q <= 1'b0;
            ser_ref_q <= 1'b0;
            rx_irq_q <= 1'b0;
            obe_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ch4_match_q <= ch4_match_d;
            c1_sel_q <= c1_sel_d;
            ser_grant_q <= ser_grant_d;
            ser_ref_q <= ser_ref_d;
            rx_irq_q <= rx_irq_d;
            obe_irq_q <= obe_irq_d;
            irq_q <= irq_d;
        end
    end

    always_comb begin
        o_rdata = rdata_q;
        o_chan4_match = ch4_match_q;
        o_chan1_sel = c1_sel_q;
        o_serial_grant = ser_grant_q;
        o_serial_refused = ser_ref_q;
        o_chan4_rx_irq = rx_irq_q;
        o_outbuf_empty_irq = obe_irq_q;
        o_chan1_enable = c1ctrl_q[`LCOB_BIT_C1EN];
        o_irq = irq_q;
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    sequence s_zero_after_one;
        wr_obser && armed_q && !i_wdata[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG];
    endsequence

    sequence s_quiet;
        !obf_any_fall && !lpc_rst;
    endsequence

    property p_ch4_off;
        (i_io_valid && !ch4ctrl_q[`LCOB_BIT_CH4_EN]) |=> !o_chan4_match;
    endproperty
    a_ch4_off: assert property (p_ch4_off)
        else $error("channel 4 matched while disabled");

    property p_rx_mask;
        (i_chan4_rx_full_irq && !ch4ctrl_q[`LCOB_BIT_CH4_RXIE])
            |=> !o_chan4_rx_irq;
    endproperty
    a_rx_mask: assert property (p_rx_mask)
        else $error("channel 4 receive request not masked");

    property p_obe_gate;
        !obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_ENABLE] |=> !o_outbuf_empty_irq;
    endproperty
    a_obe_gate: assert property (p_obe_gate)
        else $error("output-empty request passed while disabled");

    property p_obe_set;
        (obf_any_fall && !lpc_rst) |=> obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG]
            ##1 (o_outbuf_empty_irq == $past(obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_ENABLE]));
    endproperty
    a_obe_set: assert property (p_obe_set)
        else $error("output-empty flag not set on full clear");

    property p_obe_clear;
        s_zero_after_one ##0 s_quiet |=> !obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG];
    endproperty
    a_obe_clear: assert property (p_obe_clear)
        else $error("flag not cleared by zero after read of one");

    property p_obe_hold;
        (wr_obser && !armed_q) ##0 s_quiet
            |=> $stable(obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG]);
    endproperty
    a_obe_hold: assert property (p_obe_hold)
        else $error("flag changed by write without prior read");

    property p_lpc_rst;
        lpc_rst |=> !obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG] ##1 !o_outbuf_empty_irq;
    endproperty
    a_lpc_rst: assert property (p_lpc_rst)
        else $error("flag not cleared by LPC reset");

    property p_serial;
        (i_io_valid && i_serial_hit)
            |=> (o_serial_grant != o_serial_refused)
            && (o_serial_grant == $past(obser_q[`LCOB_BIT_SERE]));
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial access gating wrong");

    property p_c1_cmd;
        (i_io_valid && i_io_write && c1_hit && c1ctrl_q[`LCOB_BIT_C1EN]
            && i_io_addr[`LCOB_BIT_HOST_SEL])
            |=> o_chan1_sel == lcob_pkg::LCOB_SEL_CMD_WR;
    endproperty
    a_c1_cmd: assert property (p_c1_cmd)
        else $error("channel 1 command write not selected");

    property p_one_write;
        (wr_obser && i_wdata[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG]) ##0 s_quiet
            |=> $stable(obser_q[`LCOB_BIT_OUTBUF_EMPTY_IRQ_FLAG]);
    endproperty
    a_one_write: assert property (p_one_write)
        else $error("writing one changed the flag");

endmodule

// ===== lcob_top_test.sv
module lcob_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rstn, wr, rd, io_valid, io_write, serial_hit;
    logic rx4, hwr, swr, c4m, grant, refused, rxirq, obeirq, c1en, irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [15:0] io_addr, c4_base;
    logic [4:0] obf;
    lcob_pkg::lcob_sel_t sel;
    int n_mismatch, compares, cycles;

    lcob_top #(.AW(4), .NOBF(5)) lcob_top_inst (
        .i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_io_valid(io_valid),
        .i_io_write(io_write), .i_io_addr(io_addr),
        .i_chan4_host_address(c4_base), .i_serial_hit(serial_hit),
        .i_outbuf_full(obf), .i_chan4_rx_full_irq(rx4),
        .i_lpc_hw_reset(hwr), .i_lpc_sw_reset(swr), .o_chan4_match(c4m),
        .o_chan1_sel(sel), .o_serial_grant(grant),
        .o_serial_refused(refused), .o_chan4_rx_irq(rxirq),
        .o_outbuf_empty_irq(obeirq), .o_chan1_enable(c1en), .o_irq(irq)
    );

    lcob_host_model lcob_host_model_inst (
        .i_clk_sys(clk), .o_io_valid(io_valid), .o_io_write(io_write),
        .o_io_addr(io_addr), .o_serial_hit(serial_hit)
    );

    // ==========================================================
    // Helpers
    task automatic chk(input string what, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rd_reg(4'(i), d);
            chk("reset value", d, (i == 5) ? 8'h60 : 8'h00);
        end
        $display("test reset done");
    endtask

    task automatic t_ch4();
        lcob_host_model_inst.io(1'b1, 16'h0CA0, 1'b0);
        #1 chk("ch4 match off", c4m, 8'h00);
        wr_reg(4'h0, 8'h40);
        lcob_host_model_inst.io(1'b0, 16'h0CA4, 1'b0);
        #1 chk("ch4 match on", c4m, 8'h01);
        lcob_host_model_inst.io(1'b0, 16'h0CA8, 1'b0);
        #1 chk("ch4 other addr", c4m, 8'h00);
        $display("test ch4 done");
    endtask

    task automatic t_rx();
        @(posedge clk) rx4 <= 1'b1;
        tick(3);
        #1 chk("rx irq masked", rxirq, 8'h00);
        wr_reg(4'h0, 8'h60);
        tick(2);
        #1 chk("rx irq passed", rxirq, 8'h01);
        @(posedge clk) rx4 <= 1'b0;
        tick(2);
        wr_reg(4'h2, 8'h01);
        rd_reg(4'h2, d);
        chk("status clear", d, 8'h00);
        $display("test rx done");
    endtask

    task automatic t_obe();
        for (int i = 0; i < 7; i++) begin
            @(posedge clk) obf <= 5'(1 << (i % 5));
            tick(2);
            @(posedge clk) obf <= 5'h00;
            tick(3);
            if (i == 5) begin
                wr_reg(4'h1, 8'h00);
                rd_reg(4'h1, d);
                chk("flag kept", d, 8'h40);
                wr_reg(4'h1, 8'h40);
                rd_reg(4'h1, d);
                chk("flag one write", d, 8'h40);
                wr_reg(4'h1, 8'hC0);
                tick(2);
                #1 chk("empty irq on", obeirq, 8'h01);
                wr_reg(4'h1, 8'h40);
                tick(2);
                #1 chk("empty irq off", obeirq, 8'h00);
            end
            if (i < 5) begin
                rd_reg(4'h1, d);
                chk("flag set", d, 8'h40);
                wr_reg(4'h1, 8'h00);
            end else begin
                @(posedge clk) {hwr, swr} <= (i == 5) ? 2'b10 : 2'b01;
                @(posedge clk) {hwr, swr} <= 2'b00;
            end
            rd_reg(4'h1, d);
            chk("flag cleared", d, 8'h00);
        end
        #1 chk("irq masked", irq, 8'h00);
        wr_reg(4'h3, 8'h02);
        tick(2);
        #1 chk("irq raised", irq, 8'h01);
        wr_reg(4'h2, 8'h02);
        tick(2);
        #1 chk("irq cleared", irq, 8'h00);
        $display("test empty flag done");
    endtask

    task automatic t_serial();
        lcob_host_model_inst.io(1'b0, 16'h03F8, 1'b1);
        #1 chk("serial refused", {grant, refused}, 8'h01);
        wr_reg(4'h1, 8'h02);
        lcob_host_model_inst.io(1'b1, 16'h03F8, 1'b1);
        #1 chk("serial granted", {grant, refused}, 8'h02);
        rd_reg(4'h2, d);
        chk("refusal status", d, 8'h04);
        $display("test serial done");
    endtask

    task automatic t_chan1();
        // Address set while channel disabled
        wr_reg(4'h4, 8'h12);
        wr_reg(4'h5, 8'h35);
        rd_reg(4'h5, d);
        chk("addr low", d, 8'h31);
        wr_reg(4'h6, 8'h01);
        #1 chk("chan1 enable", c1en, 8'h01);
        for (int k = 0; k < 4; k++) begin
            lcob_host_model_inst.io(k < 2, k[0] ? 16'h1235 : 16'h1231, 1'b0);
            #1 chk("chan1 select", {5'h00, sel}, 8'(k + 1));
        end
        $display("test chan1 done");
    endtask

    // ==========================================================
    // Clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        {rstn, wr, rd, rx4, hwr, swr} = 6'h00;
        addr = 4'h0;
        wdata = 8'h00;
        obf = 5'h00;
        c4_base = 16'h0CA0;
        tick(4);
        rstn <= 1'b1;
        t_reset();
        t_ch4();
        t_rx();
        t_obe();
        t_serial();
        t_chan1();
        complete_run();
    end
endmodule
